//--- cmp_pkg.sv
// Package for the dual comparator control block.
// Assumes an SFR style 8-bit register port driven by the processor core.
package cmp_pkg;
  // ---------------------------------------------------------------
  // Register addresses (SFR page 0x00)
  // ---------------------------------------------------------------
  localparam logic [7:0] CMP0_CONTROL_ADDR = 8'h9A;
  localparam logic [7:0] CMP0_MODE_ADDR = 8'h9B;
  localparam logic [7:0] CMP1_CONTROL_ADDR = 8'h9D;
  localparam logic [7:0] CMP1_MODE_ADDR = 8'h9E;
  localparam logic [7:0] CMP0_INSEL_ADDR = 8'h9F;
  localparam logic [7:0] CMP1_INSEL_ADDR = 8'hA0;
  localparam logic [7:0] RESET_SRC_ADDR = 8'hA1;
  localparam logic [7:0] SFR_PAGE_CMP = 8'h00;
  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CTL_EN_BIT = 7;
  localparam int CTL_OUT_BIT = 6;
  localparam int CTL_RISE_BIT = 5;
  localparam int CTL_FALL_BIT = 4;
  localparam int CTL_HYP_LSB = 2;
  localparam int CTL_HYN_LSB = 0;
  // Mode register fields
  localparam int MD_RIE_BIT = 5;
  localparam int MD_FIE_BIT = 4;
  localparam int MD_MODE_LSB = 0;
  // Input select fields
  localparam int MX_NEG_LSB = 4;
  localparam int MX_POS_LSB = 0;
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] MODE_RESET = 2'h2;
  localparam logic [1:0] HYST_OFF = 2'h0;
  localparam logic [1:0] INSEL_RESET = 2'h0;
  localparam logic [1:0] SYNC_RESET = 2'h0;
endpackage : cmp_pkg

//--- cmp_channel.sv
// One comparator channel: control, mode, input select, edge flags.
// Assumes the raw analog decision arrives as an unclocked level.
`timescale 1ns/1ns
`default_nettype none
module cmp_channel (
  input wire logic i_clk_sys, // System clock
  input wire logic i_reset_n, // Async reset, active low
  input wire logic i_wr_ctl, // Write strobe, control register
  input wire logic i_wr_mode, // Write strobe, mode register
  input wire logic i_wr_insel, // Write strobe, input select
  input wire logic [7:0] i_wdata, // Write data
  input wire logic i_analog_dec, // Raw analog decision, unclocked
  output logic [7:0] o_ctl_rd, // Control register read value
  output logic [7:0] o_mode_rd, // Mode register read value
  output logic [7:0] o_insel_rd, // Input select read value
  output logic o_raw_out, // Unclocked raw output
  output logic o_latched_out, // Clock-synchronised output
  output logic o_enable, // Analog supply on
  output logic [1:0] o_pos_hyst, // Positive hysteresis select
  output logic [1:0] o_neg_hyst, // Negative hysteresis select
  output logic [1:0] o_mode, // Response mode select
  output logic [1:0] o_pos_sel, // Positive input select
  output logic [1:0] o_neg_sel, // Negative input select
  output logic o_irq // Interrupt request level
);
  logic en_ff;
  logic rise_ff;
  logic fall_ff;
  logic [1:0] hyp_ff;
  logic [1:0] hyn_ff;
  logic [1:0] mode_ff;
  logic rie_ff;
  logic fie_ff;
  logic [1:0] psel_ff;
  logic [1:0] nsel_ff;
  logic [1:0] sync_ff;
  logic prev_ff;
  logic rise_evt;
  logic fall_evt;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Enable and hysteresis fields
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_ff <= cmp_pkg::CONTROL_RESET[cmp_pkg::CTL_EN_BIT];
      hyp_ff <= cmp_pkg::HYST_OFF;
      hyn_ff <= cmp_pkg::HYST_OFF;
    end else if (i_wr_ctl) begin
      en_ff <= i_wdata[cmp_pkg::CTL_EN_BIT];
      hyp_ff <= i_wdata[cmp_pkg::CTL_HYP_LSB +: 2];
      hyn_ff <= i_wdata[cmp_pkg::CTL_HYN_LSB +: 2];
    end
  end

  // Response mode and interrupt enables; unused bits ignored
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_ff <= cmp_pkg::MODE_RESET;
      rie_ff <= 1'b0;
      fie_ff <= 1'b0;
    end else if (i_wr_mode) begin
      mode_ff <= i_wdata[cmp_pkg::MD_MODE_LSB +: 2];
      rie_ff <= i_wdata[cmp_pkg::MD_RIE_BIT];
      fie_ff <= i_wdata[cmp_pkg::MD_FIE_BIT];
    end
  end

  // Input multiplexer selects
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      psel_ff <= cmp_pkg::INSEL_RESET;
      nsel_ff <= cmp_pkg::INSEL_RESET;
    end else if (i_wr_insel) begin
      psel_ff <= i_wdata[cmp_pkg::MX_POS_LSB +: 2];
      nsel_ff <= i_wdata[cmp_pkg::MX_NEG_LSB +: 2];
    end
  end

  // ---------------------------------------------------------------
  // Output path and edge flags
  // ---------------------------------------------------------------
  // Disabled comparator reads low so no stray edges reach pins
  assign o_raw_out = en_ff & i_analog_dec;

  // Two-stage synchroniser; only stage two is looked at
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync_ff <= cmp_pkg::SYNC_RESET;
      prev_ff <= 1'b0;
    end else begin
      sync_ff <= {sync_ff[0], o_raw_out};
      prev_ff <= sync_ff[1];
    end
  end

  assign o_latched_out = sync_ff[1];
  assign rise_evt = sync_ff[1] & ~prev_ff;
  assign fall_evt = ~sync_ff[1] & prev_ff;

  // Sticky flags: set beats a software clear in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      if (rise_evt) begin
        rise_ff <= 1'b1;
      end else if (i_wr_ctl) begin
        rise_ff <= i_wdata[cmp_pkg::CTL_RISE_BIT];
      end
      if (fall_evt) begin
        fall_ff <= 1'b1;
      end else if (i_wr_ctl) begin
        fall_ff <= i_wdata[cmp_pkg::CTL_FALL_BIT];
      end
    end
  end

  assign o_irq = (rise_ff & rie_ff) | (fall_ff & fie_ff);

  // Read views; output state bit is read-only
  assign o_ctl_rd = {en_ff, sync_ff[1], rise_ff, fall_ff,
                     hyp_ff, hyn_ff};
  assign o_mode_rd = {2'h0, rie_ff, fie_ff, 2'h0, mode_ff};
  assign o_insel_rd = {2'h0, nsel_ff, 2'h0, psel_ff};
  assign o_enable = en_ff;
  assign o_pos_hyst = hyp_ff;
  assign o_neg_hyst = hyn_ff;
  assign o_mode = mode_ff;
  assign o_pos_sel = psel_ff;
  assign o_neg_sel = nsel_ff;
endmodule : cmp_channel
`default_nettype wire

//--- dual_comparator_control.sv
// Dual comparator digital control around two analog comparators.
// Assumes an SFR port: address, page, write/read strobes, 8-bit data.
`timescale 1ns/1ns
`default_nettype none
module dual_comparator_control (
  input wire logic i_clk_sys, // System clock, 250 MHz
  input wire logic i_reset_n, // Async reset, active low
  input wire logic [7:0] i_sfr_addr, // SFR address
  input wire logic [7:0] i_sfr_page, // Current SFR page
  input wire logic i_sfr_wr, // Write strobe, one cycle
  input wire logic i_sfr_rd, // Read strobe
  input wire logic [7:0] i_sfr_wdata, // Write data
  input wire logic i_cmp0_decision, // Comparator 0 analog decision
  input wire logic i_cmp1_decision, // Comparator 1 analog decision
  output logic [7:0] o_sfr_rdata, // Registered read data
  output logic o_sfr_hit, // Address maps here, combinational
  output logic o_cmp_zero_raw_out, // Comparator 0 raw output
  output logic o_cmp_one_raw_out, // Comparator 1 raw output
  output logic o_cmp_zero_latched_out, // Comparator 0 latched output
  output logic o_cmp_one_latched_out, // Comparator 1 latched output
  output logic [1:0] o_cmp_enable, // Analog supply enable per channel
  output logic [3:0] o_cmp_hyst [2], // {pos,neg} hysteresis per channel
  output logic [1:0] o_cmp_mode [2], // Response mode per channel
  output logic [3:0] o_cmp_insel [2], // {neg,pos} input select per channel
  output logic o_cmp0_irq, // Comparator 0 interrupt request
  output logic o_cmp1_irq, // Comparator 1 interrupt request
  output logic o_cmp0_reset_req // Comparator 0 system reset request
);
  logic on_page;
  logic [1:0] wr_ctl;
  logic [1:0] wr_mode;
  logic [1:0] wr_insel;
  logic wr_rst_src;
  logic [7:0] ctl_rd [2];
  logic [7:0] mode_rd [2];
  logic [7:0] insel_rd [2];
  logic [1:0] latched;
  logic [1:0] raw;
  logic [1:0] irq;
  logic [1:0] pos_hyst [2];
  logic [1:0] neg_hyst [2];
  logic [1:0] pos_sel [2];
  logic [1:0] neg_sel [2];
  logic rst_src_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] rdata_ff;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  // Page check comes first: the same addresses on any other page
  // belong to other blocks and must neither write nor answer here.
  // The strobes below are one-hot by construction, so at most one
  // register of the block is written by the bus in any cycle.
  assign on_page = (i_sfr_page == cmp_pkg::SFR_PAGE_CMP);
  assign wr_ctl[0] = i_sfr_wr & on_page &
                     hit(i_sfr_addr, cmp_pkg::CMP0_CONTROL_ADDR);
  assign wr_ctl[1] = i_sfr_wr & on_page &
                     hit(i_sfr_addr, cmp_pkg::CMP1_CONTROL_ADDR);
  assign wr_mode[0] = i_sfr_wr & on_page &
                      hit(i_sfr_addr, cmp_pkg::CMP0_MODE_ADDR);
  assign wr_mode[1] = i_sfr_wr & on_page &
                      hit(i_sfr_addr, cmp_pkg::CMP1_MODE_ADDR);
  assign wr_insel[0] = i_sfr_wr & on_page &
                       hit(i_sfr_addr, cmp_pkg::CMP0_INSEL_ADDR);
  assign wr_insel[1] = i_sfr_wr & on_page &
                       hit(i_sfr_addr, cmp_pkg::CMP1_INSEL_ADDR);
  assign wr_rst_src = i_sfr_wr & on_page &
                      hit(i_sfr_addr, cmp_pkg::RESET_SRC_ADDR);

  // ---------------------------------------------------------------
  // Channels: identical logic for both comparators
  // ---------------------------------------------------------------
  // Only the reset request below tells comparator 0 apart from 1
  for (genvar g = 0; g < 2; g++) begin : g_ch
    cmp_channel u_ch (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_wr_ctl(wr_ctl[g]),
      .i_wr_mode(wr_mode[g]),
      .i_wr_insel(wr_insel[g]),
      .i_wdata(i_sfr_wdata),
      .i_analog_dec(g == 0 ? i_cmp0_decision : i_cmp1_decision),
      .o_ctl_rd(ctl_rd[g]),
      .o_mode_rd(mode_rd[g]),
      .o_insel_rd(insel_rd[g]),
      .o_raw_out(raw[g]),
      .o_latched_out(latched[g]),
      .o_enable(o_cmp_enable[g]),
      .o_pos_hyst(pos_hyst[g]),
      .o_neg_hyst(neg_hyst[g]),
      .o_mode(o_cmp_mode[g]),
      .o_pos_sel(pos_sel[g]),
      .o_neg_sel(neg_sel[g]),
      .o_irq(irq[g])
    );
    assign o_cmp_hyst[g] = {pos_hyst[g], neg_hyst[g]};
    assign o_cmp_insel[g] = {neg_sel[g], pos_sel[g]};
  end

  assign o_cmp_zero_raw_out = raw[0];
  assign o_cmp_one_raw_out = raw[1];
  assign o_cmp_zero_latched_out = latched[0];
  assign o_cmp_one_latched_out = latched[1];
  assign o_cmp0_irq = irq[0];
  assign o_cmp1_irq = irq[1];

  // ---------------------------------------------------------------
  // Comparator 0 reset source
  // ---------------------------------------------------------------
  // Bit 0 selects comparator 0 as reset source; low level requests
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_src_ff <= 1'b0;
    end else if (wr_rst_src) begin
      rst_src_ff <= i_sfr_wdata[0];
    end
  end

  // Uses the synchronised output so a glitch cannot reset the chip
  assign o_cmp0_reset_req = rst_src_ff & o_cmp_enable[0] &
                            ~latched[0];

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Read mux; unmapped addresses answer zero
  // Reads have no side effects: flags clear only by an explicit write
  always_comb begin
    nxt_rdata = 8'h00;
    o_sfr_hit = 1'b0;
    if (on_page) begin
      o_sfr_hit = 1'b1;
      unique case (i_sfr_addr)
        cmp_pkg::CMP0_CONTROL_ADDR: nxt_rdata = ctl_rd[0];
        cmp_pkg::CMP1_CONTROL_ADDR: nxt_rdata = ctl_rd[1];
        cmp_pkg::CMP0_MODE_ADDR: nxt_rdata = mode_rd[0];
        cmp_pkg::CMP1_MODE_ADDR: nxt_rdata = mode_rd[1];
        cmp_pkg::CMP0_INSEL_ADDR: nxt_rdata = insel_rd[0];
        cmp_pkg::CMP1_INSEL_ADDR: nxt_rdata = insel_rd[1];
        cmp_pkg::RESET_SRC_ADDR: nxt_rdata = {7'h00, rst_src_ff};
        default: o_sfr_hit = 1'b0;
      endcase
    end
  end

  // Read data registered one cycle after the read strobe
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_ff <= 8'h00;
    end else if (i_sfr_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_sfr_rdata = rdata_ff;
endmodule : dual_comparator_control
`default_nettype wire

//--- cmp_chk_sva.sv
// Checker for the dual comparator block: register writes, reads,
// raw gating, synchroniser delay and the comparator 0 interrupt.
// Assumes it is bound onto the top module and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module cmp_chk (
  input wire logic i_clk_sys, // System clock
  input wire logic i_reset_n, // Async reset, active low
  input wire logic [7:0] i_sfr_addr, // Address
  input wire logic [7:0] i_sfr_page, // Page
  input wire logic i_sfr_wr, // Write strobe
  input wire logic i_sfr_rd, // Read strobe
  input wire logic [7:0] i_sfr_wdata, // Write data
  input wire logic i_cmp0_decision, // Decision 0
  input wire logic i_cmp1_decision, // Decision 1
  input wire logic [7:0] o_sfr_rdata, // Read data
  input wire logic o_sfr_hit, // Address mapped
  input wire logic o_cmp_zero_raw_out, // Raw output 0
  input wire logic o_cmp_one_raw_out, // Raw output 1
  input wire logic o_cmp_zero_latched_out, // Latched output 0
  input wire logic [1:0] o_cmp_enable, // Enables
  input wire logic [3:0] o_cmp_hyst [2], // Hysteresis selects
  input wire logic [1:0] o_cmp_mode [2], // Response modes
  input wire logic [3:0] o_cmp_insel [2], // Input selects
  input wire logic o_cmp0_irq // Interrupt 0
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  // Decode of comparator 0 accesses; other pages must never hit
  wire at_ctl = i_sfr_page == 8'h00 && i_sfr_addr == 8'h9A;
  wire w_ctl = i_sfr_wr && at_ctl;
  wire w_md = i_sfr_wr && i_sfr_page == 8'h00 && i_sfr_addr == 8'h9B;
  wire w_mx = i_sfr_wr && i_sfr_page == 8'h00 && i_sfr_addr == 8'h9F;
  logic rie_ff;
  logic fie_ff;
  // Shadow of the interrupt enables, rebuilt from bus writes
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rie_ff <= 1'b0;
      fie_ff <= 1'b0;
    end else if (w_md) begin
      rie_ff <= i_sfr_wdata[5];
      fie_ff <= i_sfr_wdata[4];
    end
  end
  sequence s_rise;
    !o_cmp_zero_latched_out ##1 o_cmp_zero_latched_out;
  endsequence
  sequence s_fall;
    o_cmp_zero_latched_out ##1 !o_cmp_zero_latched_out;
  endsequence
  a_raw_gated: assert property (
    o_cmp_zero_raw_out == (o_cmp_enable[0] && i_cmp0_decision) &&
    o_cmp_one_raw_out == (o_cmp_enable[1] && i_cmp1_decision))
    else $error("raw output not gated decision");
  a_sync_two: assert property (
    o_cmp_enable[0] && $past(o_cmp_enable[0], 3) |->
    o_cmp_zero_latched_out == $past(i_cmp0_decision, 2))
    else $error("latched output not two cycles behind");
  a_ctl_write: assert property (
    w_ctl |=> o_cmp_enable[0] == $past(i_sfr_wdata[7]) &&
    o_cmp_hyst[0] == $past(i_sfr_wdata[3:0]))
    else $error("control write not applied");
  a_mode_write: assert property (
    w_md |=> o_cmp_mode[0] == $past(i_sfr_wdata[1:0]))
    else $error("mode write not applied");
  a_insel_write: assert property (
    w_mx |=> o_cmp_insel[0] ==
    {$past(i_sfr_wdata[5:4]), $past(i_sfr_wdata[1:0])})
    else $error("input select write not applied");
  a_rd_unmapped: assert property (
    i_sfr_rd && !o_sfr_hit |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rd_control: assert property (
    i_sfr_rd && !i_sfr_wr && at_ctl |=>
    o_sfr_rdata[7] == o_cmp_enable[0] && o_sfr_rdata[3:0] == o_cmp_hyst[0])
    else $error("control read disagrees");
  a_rise_irq: assert property (
    s_rise ##0 (rie_ff && !i_sfr_wr) |=> o_cmp0_irq)
    else $error("rising edge gave no interrupt");
  a_fall_irq: assert property (
    s_fall ##0 (fie_ff && !i_sfr_wr) |=> o_cmp0_irq)
    else $error("falling edge gave no interrupt");
  a_irq_sticky: assert property (
    o_cmp0_irq && !i_sfr_wr |=> o_cmp0_irq)
    else $error("interrupt dropped without a write");
endmodule : cmp_chk
bind dual_comparator_control cmp_chk u_chk (
  .i_clk_sys, .i_reset_n, .i_sfr_addr, .i_sfr_page, .i_sfr_wr,
  .i_sfr_rd, .i_sfr_wdata, .i_cmp0_decision, .i_cmp1_decision,
  .o_sfr_rdata, .o_sfr_hit, .o_cmp_zero_raw_out, .o_cmp_one_raw_out,
  .o_cmp_zero_latched_out, .o_cmp_enable, .o_cmp_hyst, .o_cmp_mode,
  .o_cmp_insel, .o_cmp0_irq
);
`default_nettype wire

//--- cmp_front_model.sv
// Behavioural analog comparator: one unclocked decision per instance.
// Assumes the bench sets the target level, the design enable and mode.
`timescale 1ns/1ns
`default_nettype none
module cmp_front_model (
  input wire logic i_enable, // Analog supply on
  input wire logic [1:0] i_mode, // Response mode
  input wire logic i_level, // Target decision from the bench
  output logic o_decision // Decision seen by the design
);
  initial o_decision = 1'b0;
  // Slower modes answer later; unpowered, the decision flips on its
  // own so that a stale value never passes for a real one
  always @(i_level or i_enable or o_decision) begin
    o_decision <= #(3 + 4 * i_mode) i_enable ? i_level : !o_decision;
  end
endmodule : cmp_front_model
`default_nettype wire

//--- dual_comparator_control_tb.sv
// Bench: register reads checked through a queue of expected values,
// edge flags, interrupts, gating and the reset request.
// Assumes cmp_pkg, the design, the front model and the checker.
`timescale 1ns/1ns
`default_nettype none
module dual_comparator_control_tb;
  logic clk, rst_n, wr, rd, rd_seen, raw0, raw1, lat0, lat1;
  logic irq0, irq1, rreq, hit;
  logic [7:0] addr, page, wdata, rdata, c, m, x, r, v;
  logic [1:0] lvl, dec, en;
  logic [3:0] hyst [2];
  logic [1:0] mode [2];
  logic [3:0] insel [2];
  logic [7:0] exp_q [$];
  logic [15:0] rv [7] = '{16'h9A00, 16'h9B02, 16'h9D00, 16'h9E02,
    16'h9F00, 16'hA000, 16'h5500};
  logic [31:0] rs;
  int mismatches, checked, cyc;
  dual_comparator_control uut (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_sfr_addr(addr),
    .i_sfr_page(page), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata),
    .i_cmp0_decision(dec[0]), .i_cmp1_decision(dec[1]),
    .o_sfr_rdata(rdata), .o_sfr_hit(hit), .o_cmp_zero_raw_out(raw0),
    .o_cmp_one_raw_out(raw1), .o_cmp_zero_latched_out(lat0),
    .o_cmp_one_latched_out(lat1), .o_cmp_enable(en), .o_cmp_hyst(hyst),
    .o_cmp_mode(mode), .o_cmp_insel(insel), .o_cmp0_irq(irq0),
    .o_cmp1_irq(irq1), .o_cmp0_reset_req(rreq));
  for (genvar g = 0; g < 2; g++) begin : g_fe
    cmp_front_model fe (.i_enable(en[g]), .i_mode(mode[g]),
      .i_level(lvl[g]), .o_decision(dec[g]));
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction : rnd
  task automatic check(input string n, input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, e, p = 8'h00);
    @(negedge clk);
    addr = a;
    page = p;
    rd = 1'b1;
    exp_q.push_back(e);
    @(negedge clk);
    rd = 1'b0;
    page = 8'h00;
  endtask : rd_reg
  // Bounded wait for the latched output, then n cycles for the flag
  task automatic settle(input int g, input logic s, input int n);
    for (int i = 0; i < 20 && (g ? lat1 : lat0) !== s; i++) @(negedge clk);
    repeat (n) @(negedge clk);
  endtask : settle
  task automatic close_out();
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  // Read data lands one cycle after the strobe; oldest note first
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen) check("rdata", rdata, exp_q.pop_front());
  end
  // Cut a hang short well beyond the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    rs = 32'd8194;
    {rst_n, wr, rd, rd_seen, addr, page, wdata, lvl} = '0;
    repeat (16) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    foreach (rv[i]) rd_reg(rv[i][15:8], rv[i][7:0]);
    rd_reg(8'h9B, 8'h00, 8'h01);
    for (int g = 0; g < 2; g++) begin
      c = g ? 8'h9D : 8'h9A;
      m = c + 8'h01;
      x = g ? 8'hA0 : 8'h9F;
      for (int k = 0; k < 4; k++) begin
        r = rnd();
        wr_reg(m, r);
        rd_reg(m, r & 8'h33);
        check("mode", {6'h00, mode[g]}, {6'h00, r[1:0]});
        wr_reg(x, r);
        rd_reg(x, r & 8'h33);
        check("insel", {4'h0, insel[g]}, {4'h0, r[5:4], r[1:0]});
        v = {4'h8, k[1:0], 2'(3 - k)};
        wr_reg(c, v);
        settle(g, 1'b0, 12);
        wr_reg(c, v);
        rd_reg(c, v);
        check("hyst", {4'h0, hyst[g]}, {4'h0, v[3:0]});
      end
      wr_reg(m, 8'h30);
      lvl[g] = 1'b1;
      settle(g, 1'b1, 3);
      check("irq", g ? irq1 : irq0, 8'h01);
      check("raw", g ? raw1 : raw0, 8'h01);
      rd_reg(c, v | 8'h60);
      lvl[g] = 1'b0;
      settle(g, 1'b0, 3);
      rd_reg(c, v | 8'h30);
      wr_reg(c, v);
      check("irq", g ? irq1 : irq0, 8'h00);
      wr_reg(m, 8'h10);
      lvl[g] = 1'b1;
      settle(g, 1'b1, 3);
      check("irq", g ? irq1 : irq0, 8'h00);
      lvl[g] = 1'b0;
      settle(g, 1'b0, 3);
      check("irq", g ? irq1 : irq0, 8'h01);
      lvl[g] = 1'b1;
      settle(g, 1'b1, 3);
      wr_reg(c, 8'h00);
      check("raw", g ? raw1 : raw0, 8'h00);
    end
    wr_reg(8'hA1, 8'h01);
    lvl[0] = 1'b0;
    wr_reg(8'h9A, 8'h80);
    settle(0, 1'b0, 12);
    check("rreq", rreq, 8'h01);
    lvl[0] = 1'b1;
    settle(0, 1'b1, 3);
    check("rreq", rreq, 8'h00);
    close_out();
  end
endmodule : dual_comparator_control_tb
`default_nettype wire
